// ==== hw/rssh_map.svh ====
`ifndef RSSH_MAP_SVH
`define RSSH_MAP_SVH

// ============================================================
// Register offsets
`define RSSH_ADDR_GLOBAL   8'h00
`define RSSH_ADDR_ENDSW    8'h01
`define RSSH_ADDR_CAPTURE  8'h36

// ============================================================
// Reset values
`define RSSH_GLOBAL_RST    32'h0000_6020
`define RSSH_ENDSW_RST     32'h0000_0000

// ============================================================
// Field positions in global_settings
`define RSSH_BIT_CAP_REVS  27

// ============================================================
// Virtual-limit stop mode codes
`define RSSH_VMODE_HARD    2'h1
`define RSSH_VMODE_SOFT    2'h2

// ============================================================
// Timing: soft-stop ramp tick divider (cycles of clk_i per tick)
`define RSSH_RAMP_DIV_DEF  16'h0032

`endif

// ==== hw/rssh_pkg.sv ====
package rssh_pkg;

	// ============================================================
	// Layout of end_switch_settings, most significant field first
	typedef struct packed {
		logic [17:0] unused;       // Bits 31:14, not used by this block
		logic        lat_act_r;    // Capture on right switch going active
		logic        lat_inact_r;  // Capture on right switch going inactive
		logic        lat_act_l;    // Capture on left switch going active
		logic        lat_inact_l;  // Capture on left switch going inactive
		logic [1:0]  virt_mode;    // Virtual-limit stop mode
		logic        virt_r_en;    // Virtual right limit enable
		logic        virt_l_en;    // Virtual left limit enable
		logic        soft_stop;    // Ramped stop on switch events
		logic        invert_dir;   // Swap blocked directions
		logic        pol_r;        // Right switch active level
		logic        pol_l;        // Left switch active level
		logic        en_r;         // Right switch processing enable
		logic        en_l;         // Left switch processing enable
	} rssh_endsw_t;

	// ============================================================
	// Conditioned switch state
	typedef struct packed {
		logic active;    // Polarity-corrected, enabled level
		logic to_act;    // One-cycle pulse: became active
		logic to_inact;  // One-cycle pulse: became inactive
	} rssh_sw_t;

	// ============================================================
	// Stop handling states, Gray along run -> soft -> hard
	typedef enum logic [1:0] {
		RSSH_RUN  = 2'b00,
		RSSH_SOFT = 2'b01,
		RSSH_HARD = 2'b11
	} rssh_stop_t;

endpackage

// ==== hw/rssh_switch_cond.sv ====
`timescale 1ns/100ps

module rssh_switch_cond
	import rssh_pkg::*;
(
	// Clock and reset
	input  wire logic     clk_i,
	input  wire logic     arst_n_i,
	// Switch pin and its settings
	input  wire logic     raw_i,
	input  wire logic     pol_i,
	input  wire logic     en_i,
	// Conditioned result
	output rssh_sw_t      sw_o
);

	// ============================================================
	// Synchroniser
	logic sync1_r;  // First stage, read only by the second
	logic sync2_r;  // Second stage, safe to use
	logic act_r;    // Conditioned level of the previous cycle

	// Two flops against metastability on the mechanical input
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
		end else begin
			sync1_r <= raw_i;
			sync2_r <= sync1_r;
		end
	end

	// ============================================================
	// Polarity, enable and edges
	logic act_nxt;  // Active level this cycle

	// High-active when pol is one, else low-active; disabled reads idle
	always_comb begin
		act_nxt = en_i & (pol_i ? sync2_r : ~sync2_r);
	end

	// Edge detection on the corrected level, one cycle per change
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			act_r <= 1'b0;
			sw_o  <= '0;
		end else begin
			act_r           <= act_nxt;
			sw_o.active     <= act_nxt;
			sw_o.to_act     <= act_nxt & ~act_r;
			sw_o.to_inact   <= ~act_nxt & act_r;
		end
	end

endmodule

// ==== hw/rssh_top.sv ====
// Behaviour
// - Left switch used only when enabled
// - Right switch used only when enabled
// - Bit two sets left active level
// - Bit three sets right active level
// - Bit four swaps switch blocked directions
// - Switch stop hard when soft bit clear
// - Switch stop ramps when soft bit set
// - Virtual left limit needs its enable
// - Virtual right limit needs its enable
// - Virtual mode one stops hard
// - Virtual mode two ramps to zero
// - Capture position on left going inactive
// - Capture position on left going active
// - Bit 27 selects capture or revolutions
// - Capture position on right going inactive
// - Capture position on right going active
`timescale 1ns/100ps
`include "rssh_map.svh"

module rssh_top
	import rssh_pkg::*;
#(
	parameter logic [15:0] RAMP_DIV = `RSSH_RAMP_DIV_DEF  // Cycles per ramp tick
)
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              arst_n_i,
	// Register port
	input  wire logic              wr_en_i,
	input  wire logic              rd_en_i,
	input  wire logic [7:0]        addr_i,
	input  wire logic [31:0]       wdata_i,
	output logic      [31:0]       rdata_o,
	output logic                   rvalid_o,
	// Switch pins
	input  wire logic              left_limit_input_i,
	input  wire logic              right_limit_input_i,
	// Ramp generator side
	input  wire logic signed [31:0] present_velocity_i,
	input  wire logic signed [31:0] present_position_i,
	input  wire logic        [31:0] revolution_counter_i,
	input  wire logic signed [31:0] virt_left_pos_i,
	input  wire logic signed [31:0] virt_right_pos_i,
	input  wire logic        [31:0] decel_step_i,
	// Results
	output logic signed [31:0]     velocity_o,
	output rssh_stop_t             stop_state_o,
	output logic                   left_active_o,
	output logic                   right_active_o
);

	// ============================================================
	// Registers
	logic [31:0] global_settings_r;      // General configuration
	rssh_endsw_t end_switch_settings_r;  // Switch configuration
	logic [31:0] capture_r;              // Latched position

	// Software writes; only the two documented offsets hold state
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			global_settings_r     <= `RSSH_GLOBAL_RST;
			end_switch_settings_r <= `RSSH_ENDSW_RST;
		end else if (wr_en_i) begin
			if (addr_i == `RSSH_ADDR_GLOBAL) begin
				global_settings_r <= wdata_i;
			end
			if (addr_i == `RSSH_ADDR_ENDSW) begin
				end_switch_settings_r <= wdata_i;
			end
		end
	end

	// ============================================================
	// Switch conditioning
	rssh_sw_t sw_l;  // Left switch state
	rssh_sw_t sw_r;  // Right switch state

	rssh_switch_cond u_left (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.raw_i    (left_limit_input_i),
		.pol_i    (end_switch_settings_r.pol_l),
		.en_i     (end_switch_settings_r.en_l),
		.sw_o     (sw_l)
	);

	rssh_switch_cond u_right (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.raw_i    (right_limit_input_i),
		.pol_i    (end_switch_settings_r.pol_r),
		.en_i     (end_switch_settings_r.en_r),
		.sw_o     (sw_r)
	);

	// ============================================================
	// Stop decision
	logic neg_blk;    // A switch blocks negative motion
	logic pos_blk;    // A switch blocks positive motion
	logic mv_neg;     // Moving negative
	logic mv_pos;     // Moving positive
	logic sw_stop;    // Switch stop applies to present motion
	logic virt_stop;  // Virtual limit applies to present motion
	logic want_hard;  // Any stop that must be abrupt
	rssh_stop_t stop_nxt;

	// Direction assignment and stop classification
	always_comb begin
		mv_neg  = present_velocity_i < 0;
		mv_pos  = present_velocity_i > 0;
		// Left normally guards negative, swapped when inverted
		neg_blk = end_switch_settings_r.invert_dir ? sw_r.active : sw_l.active;
		pos_blk = end_switch_settings_r.invert_dir ? sw_l.active : sw_r.active;
		// Motion away from an active switch is left alone
		sw_stop = (mv_neg & neg_blk) | (mv_pos & pos_blk);
		virt_stop = (end_switch_settings_r.virt_l_en & mv_neg
				& (present_position_i <= virt_left_pos_i))
			| (end_switch_settings_r.virt_r_en & mv_pos
				& (present_position_i >= virt_right_pos_i));
		// Reserved virtual modes act as hard stop, the safer outcome
		want_hard = (sw_stop & ~end_switch_settings_r.soft_stop)
			| (virt_stop & (end_switch_settings_r.virt_mode != `RSSH_VMODE_SOFT));
		if (want_hard) begin
			stop_nxt = RSSH_HARD;
		end else if (sw_stop | virt_stop) begin
			stop_nxt = RSSH_SOFT;
		end else begin
			stop_nxt = RSSH_RUN;
		end
	end

	// ============================================================
	// Ramp tick divider
	logic [15:0] div_r;   // Cycle counter
	logic        tick_r;  // One-cycle ramp enable

	// Soft stop steps at a slower rate to form a linear ramp
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_r  <= '0;
			tick_r <= 1'b0;
		end else if (div_r >= RAMP_DIV - 16'h0001) begin
			div_r  <= '0;
			tick_r <= 1'b1;
		end else begin
			div_r  <= div_r + 16'h0001;
			tick_r <= 1'b0;
		end
	end

	// ============================================================
	// Velocity output
	logic signed [31:0] step_s;  // Step as signed magnitude
	logic signed [31:0] vel_nxt;

	// Hard forces zero at once; soft walks toward zero, clamped
	always_comb begin
		step_s  = $signed(decel_step_i);
		vel_nxt = velocity_o;
		case (stop_nxt)
			RSSH_RUN: begin
				vel_nxt = present_velocity_i;
			end
			RSSH_HARD: begin
				vel_nxt = '0;
			end
			RSSH_SOFT: begin
				// Start the ramp from the live velocity on entry from run
				if (stop_state_o == RSSH_RUN) begin
					vel_nxt = present_velocity_i;
				end else if (tick_r) begin
					if (velocity_o > 0) begin
						vel_nxt = (velocity_o > step_s) ? velocity_o - step_s : '0;
					end else if (velocity_o < 0) begin
						vel_nxt = (-velocity_o > step_s) ? velocity_o + step_s : '0;
					end
				end
			end
			default: begin
				vel_nxt = '0;
			end
		endcase
	end

	// Registered results
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			velocity_o     <= '0;
			stop_state_o   <= RSSH_RUN;
			left_active_o  <= 1'b0;
			right_active_o <= 1'b0;
		end else begin
			velocity_o     <= vel_nxt;
			stop_state_o   <= stop_nxt;
			left_active_o  <= sw_l.active;
			right_active_o <= sw_r.active;
		end
	end

	// ============================================================
	// Position capture
	logic cap_hit;  // Some enabled edge occurred

	// Each of the four edges has its own enable
	always_comb begin
		cap_hit = (sw_l.to_inact & end_switch_settings_r.lat_inact_l)
			| (sw_l.to_act & end_switch_settings_r.lat_act_l)
			| (sw_r.to_inact & end_switch_settings_r.lat_inact_r)
			| (sw_r.to_act & end_switch_settings_r.lat_act_r);
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			capture_r <= '0;
		end else if (cap_hit) begin
			capture_r <= present_position_i;
		end
	end

	// ============================================================
	// Register reads, one cycle after the request
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o  <= '0;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= rd_en_i;
			if (rd_en_i) begin
				case (addr_i)
					`RSSH_ADDR_GLOBAL:  rdata_o <= global_settings_r;
					`RSSH_ADDR_ENDSW:   rdata_o <= end_switch_settings_r;
					`RSSH_ADDR_CAPTURE: begin
						rdata_o <= global_settings_r[`RSSH_BIT_CAP_REVS]
							? revolution_counter_i : capture_r;
					end
					default:            rdata_o <= '0;
				endcase
			end
		end
	end

endmodule

// ==== bench/rssh_switch_model.sv ====
`timescale 1ns/100ps

// ============================================================
// Two mechanical end switches; pressed means active level
module rssh_switch_model (
	// Commands and wiring polarity
	input  wire logic press_l_i,
	input  wire logic press_r_i,
	input  wire logic pol_l_i,
	input  wire logic pol_r_i,
	// Switch pins
	output logic      left_o,
	output logic      right_o
);
	// A released contact sits at the opposite level, never floats
	assign left_o  = press_l_i ? pol_l_i : ~pol_l_i;
	assign right_o = press_r_i ? pol_r_i : ~pol_r_i;
endmodule

// ==== bench/rssh_top_monitor.sv ====
`timescale 1ns/100ps

module rssh_top_monitor
	import rssh_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               arst_n_i,
	input  wire logic               wr_en_i,
	input  wire logic               rd_en_i,
	input  wire logic [7:0]         addr_i,
	input  wire logic [31:0]        wdata_i,
	input  wire logic [31:0]        rdata_o,
	input  wire logic               rvalid_o,
	input  wire logic               left_limit_input_i,
	input  wire logic signed [31:0] present_velocity_i,
	input  wire logic [31:0]        revolution_counter_i,
	input  wire logic signed [31:0] velocity_o,
	input  wire rssh_stop_t         stop_state_o,
	input  wire logic               left_active_o,
	input  wire logic               right_active_o
);
	// ============================================================
	// Shadow of the settings, so checks know the configuration
	logic [31:0] cfg_r;
	logic        sel_r;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_r <= 32'h0000_0000;
		end else if (wr_en_i && addr_i == 8'h01) begin
			cfg_r <= wdata_i;
		end
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sel_r <= 1'b0;
		end else if (wr_en_i && addr_i == 8'h00) begin
			sel_r <= wdata_i[27];
		end
	end
	function automatic logic [31:0] mag(input logic signed [31:0] v);
		return (v < 0) ? -v : v;
	endfunction
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// Six samples cover the two sync stages, the conditioning flop and the output flop
	sequence s_left_on;
		(cfg_r[0] && left_limit_input_i == cfg_r[2]) [*6];
	endsequence
	sequence s_left_neg;
		(left_active_o && !cfg_r[4] && present_velocity_i < 0) [*2];
	endsequence
	// ============================================================
	// Checks
	a_revs_read: assert property (rd_en_i && addr_i == 8'h36 && sel_r
		|=> rvalid_o && rdata_o == $past(revolution_counter_i)) else $error("revs read");
	a_left_off: assert property (!cfg_r[0] [*5] |-> !left_active_o)
		else $error("left not ignored");
	a_right_off: assert property (!cfg_r[1] [*5] |-> !right_active_o)
		else $error("right not ignored");
	a_left_level: assert property (s_left_on |-> left_active_o)
		else $error("left level");
	a_hard_zero: assert property (stop_state_o == RSSH_HARD |-> velocity_o == 0)
		else $error("hard not zero");
	// The active output trails the internal level by one flop, so the next
	// sample must confirm the switch still held when the stop was decided
	a_left_hard: assert property ((s_left_neg and !cfg_r[5] [*2]) ##1 left_active_o
		|-> stop_state_o == RSSH_HARD) else $error("left hard stop");
	a_left_soft: assert property ((s_left_neg and cfg_r[5] [*2]) ##1 left_active_o
		|-> stop_state_o != RSSH_RUN) else $error("left soft stop");
	a_soft_shrink: assert property (stop_state_o == RSSH_SOFT && $past(stop_state_o) == RSSH_SOFT
		|-> mag(velocity_o) <= mag($past(velocity_o))) else $error("ramp grows");
	a_run_follow: assert property (stop_state_o == RSSH_RUN && $past(arst_n_i)
		|-> velocity_o == $past(present_velocity_i)) else $error("run velocity");
endmodule

bind rssh_top rssh_top_monitor rssh_top_monitor_i (.clk_i, .arst_n_i, .wr_en_i, .rd_en_i,
	.addr_i, .wdata_i, .rdata_o, .rvalid_o, .left_limit_input_i, .present_velocity_i,
	.revolution_counter_i, .velocity_o, .stop_state_o, .left_active_o, .right_active_o);

// ==== bench/rssh_top_tb.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end

module rssh_top_tb
	import rssh_pkg::*;
;
	logic clk_i = 1'b0, arst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, pl = 1'b0, pr = 1'b0;
	logic [7:0] ad = 8'h00;
	logic [31:0] wd = 32'h0000_0000, cfg = 32'h0000_0000, rdat, dec = 32'h0000_0064;
	logic [31:0] rev = 32'h1234_5678;  // Revolution count offered to the block
	logic signed [31:0] vel = 0, pos = 0, vl = 0, vr = 0, vo;
	logic rv, sl, sr, la, ra;
	rssh_stop_t st;
	int n_fail = 0;
	int num_checks = 0;
	always #10 clk_i = ~clk_i;
	rssh_switch_model rssh_switch_model_i (.press_l_i(pl), .press_r_i(pr),
		.pol_l_i(cfg[2]), .pol_r_i(cfg[3]), .left_o(sl), .right_o(sr));
	rssh_top #(.RAMP_DIV(16'h0002)) rssh_top_i (.clk_i, .arst_n_i, .wr_en_i(wr),
		.rd_en_i(rd), .addr_i(ad), .wdata_i(wd), .rdata_o(rdat), .rvalid_o(rv),
		.left_limit_input_i(sl), .right_limit_input_i(sr), .present_velocity_i(vel),
		.present_position_i(pos), .revolution_counter_i(rev),
		.virt_left_pos_i(vl), .virt_right_pos_i(vr), .decel_step_i(dec),
		.velocity_o(vo), .stop_state_o(st), .left_active_o(la), .right_active_o(ra));
	// ============================================================
	// Register port: one-cycle strobes, driven on the falling edge
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk_i);
		wr = 1'b1; ad = a; wd = d;
		@(negedge clk_i);
		wr = 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(negedge clk_i);
		rd = 1'b1; ad = a;
		@(negedge clk_i);
		rd = 1'b0;
		`CHK(nm, {1'b1, e}, {rv, rdat})
	endtask
	task automatic setc(input logic [31:0] c);
		cfg = c;
		wreg(8'h01, c);
	endtask
	// Output lags the pin by four edges; six leaves margin
	task automatic settle;
		repeat (6) @(negedge clk_i);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ============================================================
	// Scenarios
	task automatic t_regs;
		rreg(8'h00, 32'h0000_6020, "global");
		rreg(8'h01, 32'h0000_0000, "endsw");
		rreg(8'h05, 32'h0000_0000, "unmapped");
		wreg(8'h00, 32'h0800_6020);
		rreg(8'h36, 32'h1234_5678, "revs");
		rev = 32'h0000_0ABC;
		rreg(8'h36, 32'h0000_0ABC, "revs follow");
		wreg(8'h00, 32'h0000_6020);
		$display("t_regs done");
	endtask
	task automatic t_levels;
		for (int k = 0; k < 4; k++) begin
			setc({28'h000_0000, k[1], k[1], k[0], k[0]});
			pl = 1'b1; pr = 1'b1; settle;
			`CHK("active", {k[0], k[0]}, {la, ra})
			pl = 1'b0; pr = 1'b0; settle;
			`CHK("idle", 2'b00, {la, ra})
		end
		$display("t_levels done");
	endtask
	task automatic t_sw_stop;
		int i;
		setc(32'h0000_0005); vel = -32'sh0000_0064; pl = 1'b1; settle;
		`CHK("hard", {RSSH_HARD, 32'h0000_0000}, {st, vo})
		vel = 32'sh0000_0064; settle;
		`CHK("away", {RSSH_RUN, vel}, {st, vo})
		setc(32'h0000_0015); settle;
		`CHK("swapped", RSSH_HARD, st)
		pl = 1'b0; vel = -32'sh0000_03E8; setc(32'h0000_0025); settle;
		pl = 1'b1; settle;
		`CHK("soft", {RSSH_SOFT, 1'b1}, {st, vo < 0})
		for (i = 0; i < 100 && vo !== 0; i++)
			@(negedge clk_i);
		`CHK("ramp end", 32'h0000_0000, vo)
		if (i == 100) tally_and_finish;
		pl = 1'b0; setc(32'h0000_0000); settle;
		$display("t_sw_stop done");
	endtask
	task automatic t_virtual;
		logic [31:0] c[4] = '{32'h0000_0100, 32'h0000_0140, 32'h0000_0240, 32'h0000_0180};
		rssh_stop_t e[4] = '{RSSH_RUN, RSSH_HARD, RSSH_SOFT, RSSH_HARD};
		for (int k = 0; k < 4; k++) begin
			vel = (k == 3) ? 32'sh0000_0064 : -32'sh0000_0064;
			pos = (k == 3) ? 32'sh0000_000A : -32'sh0000_000A;
			setc(c[k]); settle;
			`CHK("virtual", e[k], st)
			setc(32'h0000_0000); settle;
		end
		vel = 0;
		$display("t_virtual done");
	endtask
	task automatic t_capture;
		for (int k = 0; k < 4; k++) begin
			setc(32'h0000_000F | (32'h0000_0400 << k));
			pos = 32'sh0000_0100 + k;
			if (k < 2) pl = 1'b1; else pr = 1'b1;
			settle;
			pos = 32'sh0000_0200 + k;
			pl = 1'b0; pr = 1'b0; settle;
			rreg(8'h36, (k[0] ? 32'h0000_0100 : 32'h0000_0200) + k, "capture");
		end
		$display("t_capture done");
	endtask
	initial begin
		repeat (8) @(negedge clk_i);
		arst_n_i = 1'b1;
		t_regs;
		t_levels;
		t_sw_stop;
		t_virtual;
		t_capture;
		tally_and_finish;
	end
endmodule
